// *** src/flash_option_bit_loader.sv ***
// Contract
// - Option bit changes in flash take effect only after the next reset.
// - Every reset kind fetches option bits from flash into option registers.
// - Options are loaded before the processor is released from reset.
// - Option registers have no software read or write path.
// - User option bits come from program memory bytes 0 and 1.
// - Trim bits live in the information page, untouched by erase.
// - Working trim values return to factory values on any reset.
// - Software loads trim index, then next data write updates that byte.
// - Data register read returns working value of selected trim byte.
// - Trim index reaches only information addresses 20 to 3F.
// - Calibration bytes readable by program memory loads into info area.
// - Serial number in information page survives mass erase.
// - Serial bytes at FE1C..FE1F, most significant at lowest address.
// - Lot identifier is 32 info page bytes, unchanged by reset.
// - Option bits select watchdog interrupt or reset and always-on.
// - Option bit selects brownout detection on or off in stop mode.
// - Option bits give read protection and program or erase protection.
`timescale 1ns/100ps
`default_nettype none
module flash_option_bit_loader #(
    parameter int PROG_AW = flash_option_pkg::PROG_AW,
    parameter int COUNT   = flash_option_pkg::TRIM_COUNT,
    parameter int IW      = flash_option_pkg::TRIM_IW
) (
    input  wire logic                             clk,
    input  wire logic                             arst_n,
    input  wire logic                             sys_reset_req,
    input  wire logic                             stop_recovery,
    output logic                                  cpu_hold_r,
    output flash_option_pkg::option_cfg_type      option_cfg,
    output logic      [COUNT-1:0][7:0]            trim_values,
    output logic                                  flash_rd_r,
    output logic                                  flash_info_r,
    output logic      [PROG_AW-1:0]               flash_addr_r,
    input  wire logic [7:0]                       flash_rdata,
    input  wire logic                             flash_ack,
    input  wire logic                             reg_wr,
    input  wire logic                             reg_rd,
    input  wire logic [3:0]                       reg_addr,
    input  wire logic [7:0]                       reg_wdata,
    output logic      [7:0]                       reg_rdata_r,
    output logic                                  reg_rvalid_r,
    input  wire logic                             ldc_req,
    input  wire logic [15:0]                      ldc_addr,
    output logic      [7:0]                       ldc_rdata_r,
    output logic                                  ldc_ack_r
);

    typedef enum logic [1:0] {
        LOAD_USER0,
        LOAD_USER1,
        LOAD_TRIM,
        RUN
    } load_state_type;

    load_state_type  state_r;
    logic            wait_r;
    logic            ldc_own_r;
    logic            restart_pend_r;
    logic [IW-1:0]   trim_cnt_r;
    logic [IW-1:0]   trim_idx_r;
    logic [7:0]      trim_rd_data;
    logic            loading;
    logic            issue_load;
    logic            issue_ldc;
    logic            take_restart;
    logic            load_ack;
    logic            last_trim;
    logic            sw_trim_wr;
    logic            store_wr;
    logic [IW-1:0]   store_idx;
    logic [7:0]      store_data;
    logic            opt_load0;
    logic            opt_load1;

    // Information page window of the memory map
    function automatic logic is_info_addr(input logic [15:0] addr);
        is_info_addr = (addr[15:7] == flash_option_pkg::INFO_WIN_TAG);
    endfunction

    function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    assign loading      = (state_r != RUN);
    assign issue_load   = loading && !wait_r;
    assign take_restart = (state_r == RUN) && restart_pend_r && !wait_r;
    assign issue_ldc    = (state_r == RUN) && ldc_req && !wait_r && !restart_pend_r;
    assign load_ack     = loading && wait_r && flash_ack && !ldc_own_r;
    assign last_trim    = (trim_cnt_r == IW'(COUNT - 1));
    assign sw_trim_wr   = (state_r == RUN) && reg_wr
                          && reg_hit(reg_addr, flash_option_pkg::TRIM_DATA_OFS);
    assign opt_load0    = load_ack && (state_r == LOAD_USER0);
    assign opt_load1    = load_ack && (state_r == LOAD_USER1);

    // Loader has the trim store during load, software afterwards
    always_comb begin
        store_wr   = sw_trim_wr;
        store_idx  = trim_idx_r;
        store_data = reg_wdata;
        if (load_ack && (state_r == LOAD_TRIM)) begin
            store_wr   = 1'b1;
            store_idx  = trim_cnt_r;
            store_data = flash_rdata;
        end
    end

    // Reset events latch until the load sequence is back in RUN and the flash port is free; set wins over take
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            restart_pend_r <= 1'b0;
        end else if (sys_reset_req || stop_recovery) begin
            restart_pend_r <= 1'b1;
        end else if (take_restart) begin
            restart_pend_r <= 1'b0;
        end
    end

    // Load sequence: user byte 0, user byte 1, then the 32 trim bytes
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_r    <= LOAD_USER0;
            trim_cnt_r <= '0;
        end else begin
            case (state_r)
                LOAD_USER0: begin
                    if (load_ack) begin
                        state_r <= LOAD_USER1;
                    end
                end
                LOAD_USER1: begin
                    if (load_ack) begin
                        state_r    <= LOAD_TRIM;
                        trim_cnt_r <= '0;
                    end
                end
                LOAD_TRIM: begin
                    if (load_ack) begin
                        if (last_trim) begin
                            state_r <= RUN;
                        end else begin
                            trim_cnt_r <= trim_cnt_r + 1'b1;
                        end
                    end
                end
                RUN: begin
                    if (take_restart) begin
                        state_r <= LOAD_USER0;
                    end
                end
                default: begin
                    state_r <= LOAD_USER0;
                end
            endcase
        end
    end

    // Processor stays held until the last trim byte is in
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_hold_r <= 1'b1;
        end else if (take_restart) begin
            cpu_hold_r <= 1'b1;
        end else if (load_ack && (state_r == LOAD_TRIM) && last_trim) begin
            cpu_hold_r <= 1'b0;
        end
    end

    // Flash read port; it has no write path, so info page bytes never change
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            flash_rd_r   <= 1'b0;
            flash_info_r <= 1'b0;
            flash_addr_r <= '0;
            wait_r       <= 1'b0;
            ldc_own_r    <= 1'b0;
        end else begin
            flash_rd_r <= 1'b0;
            if (issue_load) begin
                flash_rd_r <= 1'b1;
                wait_r     <= 1'b1;
                ldc_own_r  <= 1'b0;
                case (state_r)
                    LOAD_USER0: begin
                        flash_info_r <= 1'b0;
                        flash_addr_r <= PROG_AW'(flash_option_pkg::USER_BYTE0_ADDR);
                    end
                    LOAD_USER1: begin
                        flash_info_r <= 1'b0;
                        flash_addr_r <= PROG_AW'(flash_option_pkg::USER_BYTE1_ADDR);
                    end
                    default: begin
                        flash_info_r <= 1'b1;
                        flash_addr_r <= PROG_AW'(flash_option_pkg::TRIM_INFO_BASE
                                                 | 7'(trim_cnt_r));
                    end
                endcase
            end else if (issue_ldc) begin
                flash_rd_r <= 1'b1;
                wait_r     <= 1'b1;
                ldc_own_r  <= 1'b1;
                if (is_info_addr(ldc_addr)) begin
                    flash_info_r <= 1'b1;
                    flash_addr_r <= PROG_AW'(ldc_addr[6:0]);
                end else begin
                    flash_info_r <= 1'b0;
                    flash_addr_r <= ldc_addr[PROG_AW-1:0];
                end
            end else if (wait_r && flash_ack) begin
                wait_r    <= 1'b0;
                ldc_own_r <= 1'b0;
            end
        end
    end

    // Program memory load answers; serial and lot bytes come back as stored
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            ldc_ack_r   <= 1'b0;
            ldc_rdata_r <= flash_option_pkg::BYTE_RESET;
        end else begin
            ldc_ack_r <= 1'b0;
            if (wait_r && flash_ack && ldc_own_r) begin
                ldc_ack_r   <= 1'b1;
                ldc_rdata_r <= flash_rdata;
            end
        end
    end

    // Trim index register, five bits wide so it can only select 0..31
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            trim_idx_r <= flash_option_pkg::TRIM_IDX_RESET;
        end else if (take_restart) begin
            trim_idx_r <= flash_option_pkg::TRIM_IDX_RESET;
        end else if ((state_r == RUN) && reg_wr
                     && reg_hit(reg_addr, flash_option_pkg::TRIM_ADDR_OFS)) begin
            trim_idx_r <= reg_wdata[IW-1:0];
        end
    end

    // Register reads; option registers have no offset here at all
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rvalid_r <= 1'b0;
            reg_rdata_r  <= flash_option_pkg::BYTE_RESET;
        end else begin
            reg_rvalid_r <= reg_rd && (state_r == RUN);
            if (reg_rd && (state_r == RUN)) begin
                if (reg_hit(reg_addr, flash_option_pkg::TRIM_ADDR_OFS)) begin
                    reg_rdata_r <= 8'(trim_idx_r);
                end else if (reg_hit(reg_addr, flash_option_pkg::TRIM_DATA_OFS)) begin
                    reg_rdata_r <= trim_rd_data;
                end else begin
                    reg_rdata_r <= flash_option_pkg::BYTE_RESET;
                end
            end
        end
    end

    // Options change only at the load steps of a reset sequence
    option_latch u_option_latch (
        .clk        (clk),
        .arst_n     (arst_n),
        .load_byte0 (opt_load0),
        .load_byte1 (opt_load1),
        .load_data  (flash_rdata),
        .cfg_r      (option_cfg)
    );

    trim_store #(
        .COUNT (COUNT),
        .IW    (IW)
    ) u_trim_store (
        .clk     (clk),
        .arst_n  (arst_n),
        .wr_en   (store_wr),
        .wr_idx  (store_idx),
        .wr_data (store_data),
        .rd_idx  (trim_idx_r),
        .rd_data (trim_rd_data),
        .mem_r   (trim_values)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence last_trim_ack_s;
        (state_r == LOAD_TRIM) && load_ack && last_trim;
    endsequence

    sequence restart_taken_s;
        (state_r == RUN) && restart_pend_r && !wait_r;
    endsequence

    chk_hold_until_loaded: assert property (
        $fell(cpu_hold_r) |-> $past((state_r == LOAD_TRIM) && load_ack && last_trim))
        else $error("processor released before options loaded");

    chk_release_after_load: assert property (
        last_trim_ack_s |=> !cpu_hold_r && (state_r == RUN))
        else $error("processor not released after last trim byte");

    chk_options_frozen: assert property (
        (!cpu_hold_r && $past(!cpu_hold_r)) |-> $stable(option_cfg))
        else $error("option configuration changed while running");

    chk_restart_reload: assert property (
        restart_taken_s |=> cpu_hold_r && (state_r == LOAD_USER0)
                            ##[1:2] (flash_rd_r && !flash_info_r))
        else $error("reset event did not restart the option load");

    chk_user_byte_addr: assert property (
        (flash_rd_r && (state_r == LOAD_USER0)) |-> !flash_info_r
            && (flash_addr_r == flash_option_pkg::USER_BYTE0_ADDR))
        else $error("user option byte read from wrong location");

    chk_trim_window: assert property (
        (flash_rd_r && (state_r == LOAD_TRIM)) |-> flash_info_r
            && (flash_addr_r[PROG_AW-1:5] == 7'h01))
        else $error("trim load outside information range 20 to 3F");

    chk_trim_readback: assert property (
        ((state_r == RUN) && reg_rd
            && reg_hit(reg_addr, flash_option_pkg::TRIM_DATA_OFS))
        |=> reg_rvalid_r && (reg_rdata_r == $past(trim_rd_data)))
        else $error("trim data read returned wrong byte");

    chk_ldc_info_map: assert property (
        (issue_ldc && is_info_addr(ldc_addr))
        |=> flash_rd_r && flash_info_r
            && (flash_addr_r[6:0] == $past(ldc_addr[6:0])))
        else $error("information page load mapped to wrong byte");

    chk_trim_reload: assert property (
        (load_ack && (state_r == LOAD_TRIM))
        |=> trim_values[$past(trim_cnt_r)] == $past(flash_rdata))
        else $error("factory trim byte not restored");

endmodule
`default_nettype wire

// *** src/flash_option_pkg.sv ***
package flash_option_pkg;

    // Flash geometry and trim area
    localparam int PROG_AW     = 12;
    localparam int INFO_AW     = 7;
    localparam int TRIM_COUNT  = 32;
    localparam int TRIM_IW     = 5;

    // Flash locations read by the loader
    localparam logic [11:0] USER_BYTE0_ADDR = 12'h000;
    localparam logic [11:0] USER_BYTE1_ADDR = 12'h001;
    localparam logic [6:0]  TRIM_INFO_BASE  = 7'h20;

    // Memory window onto the information page
    localparam logic [8:0]  INFO_WIN_TAG    = 9'h1FC;
    localparam logic [15:0] SERIAL_FIRST    = 16'hFE1C;
    localparam logic [15:0] SERIAL_LAST     = 16'hFE1F;

    // Software register offsets
    localparam logic [3:0]  TRIM_ADDR_OFS   = 4'h0;
    localparam logic [3:0]  TRIM_DATA_OFS   = 4'h1;

    // User option byte 0 field positions
    localparam int WDT_IRQ_BIT   = 7;
    localparam int WDT_ON_BIT    = 6;
    localparam int VBO_STOP_BIT  = 5;
    localparam int RD_PROT_BIT   = 4;
    localparam int WR_PROT_BIT   = 3;

    // Reset values
    localparam logic [4:0]  TRIM_IDX_RESET  = 5'h00;
    localparam logic [7:0]  TRIM_BYTE_RESET = 8'h00;
    localparam logic [7:0]  BYTE_RESET      = 8'h00;

    typedef struct packed {
        logic       wdt_irq_mode;
        logic       wdt_always_on;
        logic       vbo_stop_enable;
        logic       read_protect;
        logic       write_protect_all;
        logic [7:0] block_protect;
    } option_cfg_type;

    localparam option_cfg_type OPTION_CFG_RESET = '{
        wdt_irq_mode:      1'b0,
        wdt_always_on:     1'b0,
        vbo_stop_enable:   1'b0,
        read_protect:      1'b0,
        write_protect_all: 1'b0,
        block_protect:     8'h00
    };

endpackage

// *** src/option_latch.sv ***
`timescale 1ns/100ps
`default_nettype none
module option_latch (
    input  wire logic                            clk,
    input  wire logic                            arst_n,
    input  wire logic                            load_byte0,
    input  wire logic                            load_byte1,
    input  wire logic [7:0]                      load_data,
    output var  flash_option_pkg::option_cfg_type cfg_r
);

    // Hidden holding registers: no software path reaches them
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            cfg_r <= flash_option_pkg::OPTION_CFG_RESET;
        end else if (load_byte0) begin
            cfg_r.wdt_irq_mode      <= load_data[flash_option_pkg::WDT_IRQ_BIT];
            cfg_r.wdt_always_on     <= load_data[flash_option_pkg::WDT_ON_BIT];
            cfg_r.vbo_stop_enable   <= load_data[flash_option_pkg::VBO_STOP_BIT];
            cfg_r.read_protect      <= load_data[flash_option_pkg::RD_PROT_BIT];
            cfg_r.write_protect_all <= load_data[flash_option_pkg::WR_PROT_BIT];
        end else if (load_byte1) begin
            cfg_r.block_protect <= load_data;
        end
    end

    chk_opt_byte0_load: assert property (@(posedge clk) disable iff (!arst_n)
        load_byte0 |=> cfg_r.wdt_irq_mode == $past(load_data[flash_option_pkg::WDT_IRQ_BIT])
                   && cfg_r.vbo_stop_enable == $past(load_data[flash_option_pkg::VBO_STOP_BIT]))
        else $error("option byte 0 not captured");

    chk_opt_byte1_load: assert property (@(posedge clk) disable iff (!arst_n)
        load_byte1 |=> cfg_r.block_protect == $past(load_data))
        else $error("option byte 1 not captured");

endmodule
`default_nettype wire

// *** src/trim_store.sv ***
`timescale 1ns/100ps
`default_nettype none
module trim_store #(
    parameter int COUNT = flash_option_pkg::TRIM_COUNT,
    parameter int IW    = flash_option_pkg::TRIM_IW
) (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  wr_en,
    input  wire logic [IW-1:0]         wr_idx,
    input  wire logic [7:0]            wr_data,
    input  wire logic [IW-1:0]         rd_idx,
    output logic      [7:0]            rd_data,
    output logic      [COUNT-1:0][7:0] mem_r
);

    // Working copies only; the factory bytes in flash are never written
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mem_r <= '{default: flash_option_pkg::TRIM_BYTE_RESET};
        end else if (wr_en) begin
            mem_r[wr_idx] <= wr_data;
        end
    end

    assign rd_data = mem_r[rd_idx];

    chk_trim_byte_write: assert property (@(posedge clk) disable iff (!arst_n)
        wr_en |=> mem_r[$past(wr_idx)] == $past(wr_data))
        else $error("trim byte write lost");

endmodule
`default_nettype wire

// *** verification/flash_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module flash_model (
    input  wire logic        clk,
    input  wire logic        rd,
    input  wire logic        info,
    input  wire logic [11:0] addr,
    input  wire logic [2:0]  lat,
    output logic      [7:0]  rdata,
    output logic             ack
);
    logic [7:0]  prog [0:4095];
    // No write or erase path, so trim, serial and lot bytes stay put
    logic [7:0]  info_mem [0:127];
    logic        pend = 1'b0;
    logic [2:0]  wt;
    logic        sel;
    logic [11:0] a;
    initial ack = 1'b0;
    initial rdata = 8'h00;
    always @(posedge clk) begin
        ack <= 1'b0;
        // Data lines keep toggling outside an answer
        rdata <= ~rdata;
        if (rd) begin
            pend <= 1'b1;
            wt <= lat - 3'h1;
            sel <= info;
            a <= addr;
        end else if (pend && wt != 3'h0) begin
            wt <= wt - 3'h1;
        end else if (pend) begin
            pend <= 1'b0;
            ack <= 1'b1;
            rdata <= sel ? info_mem[a[6:0]] : prog[a];
        end
    end
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic        clk, arst_n, sys_reset_req, stop_recovery, cpu_hold_r;
    logic        flash_rd_r, flash_info_r, flash_ack, reg_wr, reg_rd;
    logic        reg_rvalid_r, ldc_req, ldc_ack_r;
    logic [11:0] flash_addr_r;
    logic [7:0]  flash_rdata, reg_wdata, reg_rdata_r, ldc_rdata_r, rd, idx, d;
    logic [3:0]  reg_addr;
    logic [15:0] ldc_addr;
    logic [2:0]  lat;
    logic [31:0][7:0] trim_values;
    logic [7:0]  exp_trim [0:31];
    flash_option_pkg::option_cfg_type option_cfg, old_cfg;
    int          fails, checked;

    flash_option_bit_loader DUT (.clk(clk), .arst_n(arst_n), .sys_reset_req(sys_reset_req),
        .stop_recovery(stop_recovery), .cpu_hold_r(cpu_hold_r), .option_cfg(option_cfg),
        .trim_values(trim_values), .flash_rd_r(flash_rd_r), .flash_info_r(flash_info_r),
        .flash_addr_r(flash_addr_r), .flash_rdata(flash_rdata), .flash_ack(flash_ack),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata_r(reg_rdata_r), .reg_rvalid_r(reg_rvalid_r), .ldc_req(ldc_req),
        .ldc_addr(ldc_addr), .ldc_rdata_r(ldc_rdata_r), .ldc_ack_r(ldc_ack_r));
    flash_model mdl (.clk(clk), .rd(flash_rd_r), .info(flash_info_r), .addr(flash_addr_r),
        .lat(lat), .rdata(flash_rdata), .ack(flash_ack));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    function automatic flash_option_pkg::option_cfg_type exp_cfg(input logic [7:0] b0,
                                                                 input logic [7:0] b1);
        return '{b0[7], b0[6], b0[5], b0[4], b0[3], b1};
    endfunction

    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            fails++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic tally_and_finish;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk_load;
        chk("option_cfg", 16'(exp_cfg(mdl.prog[0], mdl.prog[1])), 16'(option_cfg));
        for (int i = 0; i < 32; i++) begin
            exp_trim[i] = mdl.info_mem[8'h20 + i];
            chk("trim_value", 16'(exp_trim[i]), 16'(trim_values[i]));
        end
    endtask

    task automatic wait_run;
        int n;
        n = 0;
        while (cpu_hold_r !== 1'b0 && n < 1000) begin
            @(negedge clk);
            n++;
        end
        chk("cpu_hold", 16'h0000, {15'h0, cpu_hold_r});
    endtask

    task automatic reload(input logic stop);
        int n;
        n = 0;
        if (stop) stop_recovery = 1'b1;
        else sys_reset_req = 1'b1;
        @(negedge clk);
        stop_recovery = 1'b0;
        sys_reset_req = 1'b0;
        while (cpu_hold_r !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk("hold_set", 16'h0001, {15'h0, cpu_hold_r});
        wait_run;
        chk_load;
    endtask

    task automatic reg_write(input logic [3:0] a, input logic [7:0] v);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = v;
        @(negedge clk);
        reg_wr = 1'b0;
        @(negedge clk);
    endtask

    task automatic reg_read(input logic [3:0] a, output logic [7:0] v);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        chk("reg_rvalid", 16'h0001, {15'h0, reg_rvalid_r});
        v = reg_rdata_r;
        @(negedge clk);
    endtask

    task automatic program_memory_load_instruction(input logic [15:0] a, input logic [7:0] e);
        int n;
        n = 0;
        ldc_req = 1'b1;
        ldc_addr = a;
        @(negedge clk);
        while (ldc_ack_r !== 1'b1 && n < 50) begin
            @(negedge clk);
            n++;
        end
        ldc_req = 1'b0;
        chk("ldc_ack", 16'h0001, {15'h0, ldc_ack_r});
        chk("ldc_data", {8'h00, e}, {8'h00, ldc_rdata_r});
        @(negedge clk);
    endtask

    initial begin
        #2_000_000;
        fails++;
        tally_and_finish;
    end

    initial begin
        {arst_n, sys_reset_req, stop_recovery, reg_wr, reg_rd, ldc_req} = 6'h00;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        ldc_addr = 16'h0000;
        lat = 3'h1;
        void'($urandom(32'h7bc7));
        for (int i = 0; i < 4096; i++) mdl.prog[i] = 8'($urandom());
        for (int i = 0; i < 128; i++) mdl.info_mem[i] = 8'($urandom());
        repeat (4) @(negedge clk);
        arst_n = 1'b1;
        wait_run;
        chk_load;
        $display("test power_on_load done");
        for (int k = 0; k < 10; k++) begin
            idx = (k == 0) ? 8'h1f : (k == 1) ? 8'he3 : 8'($urandom());
            d = 8'($urandom());
            reg_write(flash_option_pkg::TRIM_ADDR_OFS, idx);
            reg_write(flash_option_pkg::TRIM_DATA_OFS, d);
            exp_trim[idx[4:0]] = d;
            chk("trim_write", 16'(d), 16'(trim_values[idx[4:0]]));
            reg_read(flash_option_pkg::TRIM_DATA_OFS, rd);
            chk("trim_read", 16'(d), 16'(rd));
            reg_read(flash_option_pkg::TRIM_ADDR_OFS, rd);
            chk("trim_index", {11'h0, idx[4:0]}, 16'(rd));
        end
        for (int i = 0; i < 32; i++) chk("trim_all", 16'(exp_trim[i]), 16'(trim_values[i]));
        $display("test trim_access done");
        old_cfg = option_cfg;
        for (int a = 2; a < 16; a++) begin
            reg_write(4'(a), 8'($urandom()));
            reg_read(4'(a), rd);
            chk("unmapped_read", 16'h0000, 16'(rd));
        end
        chk("cfg_hidden", 16'(old_cfg), 16'(option_cfg));
        $display("test unmapped done");
        mdl.prog[0] = ~mdl.prog[0];
        mdl.prog[1] = 8'($urandom());
        repeat (20) @(negedge clk);
        chk("cfg_before_reset", 16'(old_cfg), 16'(option_cfg));
        lat = 3'h5;
        reload(1'b0);
        reg_read(flash_option_pkg::TRIM_ADDR_OFS, rd);
        chk("index_after_reset", 16'h0000, 16'(rd));
        mdl.prog[0] = 8'($urandom());
        lat = 3'h2;
        reload(1'b1);
        $display("test reloads done");
        for (int i = 0; i < 4; i++) program_memory_load_instruction(16'hfe1c + 16'(i), mdl.info_mem[8'h1c + i]);
        program_memory_load_instruction(16'hfe3c, mdl.info_mem[8'h3c]);
        program_memory_load_instruction(16'hfe7d, mdl.info_mem[8'h7d]);
        idx = 8'($urandom());
        program_memory_load_instruction({8'h00, idx}, mdl.prog[idx]);
        $display("test memory_load done");
        tally_and_finish;
    end
endmodule
`default_nettype wire
